//--- design/plane_latch_shifter.sv
/*
  Display memory data path: host read latches, refresh latches, the pixel
  shifter and the plane bus drivers of a four-plane graphics controller.
  Assumes the sequencer strobes and the pixel shift clock are slow against
  sys_clk_i, since all of them are sampled through two flip-flops.
*/
`timescale 1ns/1ps
module plane_latch_shifter (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       host_read_latch_n_i,
  input  wire logic       display_fetch_strobe_n_i,
  input  wire logic       pixel_shift_clock_i,
  input  wire logic       shift_load_sel_i,
  input  wire logic       memory_read_strobe_n_i,
  input  wire logic       io_write_strobe_n_i,
  input  wire logic       plane_drive_n_i,
  input  wire logic       text_mode_i,
  input  wire logic [1:0] read_plane_sel_i,
  input  wire logic [7:0] host_data_i,
  output logic      [7:0] host_data_o,
  output logic            host_data_oe_o,
  input  wire logic [7:0] plane0_bus_i,
  input  wire logic [7:0] plane1_bus_i,
  input  wire logic [7:0] plane2_bus_i,
  input  wire logic [7:0] plane3_bus_i,
  output logic      [7:0] plane0_bus_o,
  output logic      [7:0] plane1_bus_o,
  output logic      [7:0] plane2_bus_o,
  output logic      [7:0] plane3_bus_o,
  output logic            plane_bus_oe_o,
  output logic      [3:0] pixel_code_out_o
);
  localparam int W = plane_latch_pkg::PLANE_W;

  logic [plane_latch_pkg::SYNC_W-1:0] pins;
  logic [W-1:0]                       rd_latch [plane_latch_pkg::PLANES];
  logic [W-1:0]                       fetch_latch [plane_latch_pkg::PLANES];
  logic [W-1:0]                       shifter [plane_latch_pkg::PLANES];
  logic [W-1:0]                       write_reg;
  logic                               read_n_q;
  logic                               fetch_n_q;
  logic                               pixclk_q;

  // Rising edge of a synchronised level against its previous sample.
  function automatic logic rose(input logic prev, input logic now);
    return !prev && now;
  endfunction

  // Every pin, data included, passes the same two stages so that data and
  // the strobe that qualifies it stay aligned to the same cycle.
  pin_sync #(
    .WIDTH   (plane_latch_pkg::SYNC_W),
    .RST_VAL (plane_latch_pkg::SYNC_RST)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   ({host_data_i, plane3_bus_i, plane2_bus_i, plane1_bus_i, plane0_bus_i,
                 read_plane_sel_i, text_mode_i, plane_drive_n_i, io_write_strobe_n_i,
                 memory_read_strobe_n_i, shift_load_sel_i, pixel_shift_clock_i,
                 display_fetch_strobe_n_i, host_read_latch_n_i}),
    .sync_o    (pins)
  );

  // Named views of the synchronised pins.
  wire         read_n   = pins[plane_latch_pkg::POS_READ_N];
  wire         fetch_n  = pins[plane_latch_pkg::POS_FETCH_N];
  wire         pixclk   = pins[plane_latch_pkg::POS_PIXCLK];
  wire         shload   = pins[plane_latch_pkg::POS_SHLOAD];
  wire         mrd_n    = pins[plane_latch_pkg::POS_MRD_N];
  wire         iow_n    = pins[plane_latch_pkg::POS_IOW_N];
  wire         drive_n  = pins[plane_latch_pkg::POS_DRIVE_N];
  wire         text     = pins[plane_latch_pkg::POS_TEXT];
  wire [1:0]   rd_sel   = pins[plane_latch_pkg::POS_SEL +: plane_latch_pkg::SEL_W];
  wire [W-1:0] host_in  = pins[plane_latch_pkg::POS_HOST +: W];
  wire [W-1:0] plane_in [plane_latch_pkg::PLANES];

  for (genvar p = 0; p < plane_latch_pkg::PLANES; p++)
  begin : g_plane_view
    assign plane_in[p] = pins[plane_latch_pkg::POS_PLANES + p * W +: W];
  end

  // Edge events and the next pixel code.
  wire       read_rise  = rose(read_n_q, read_n);
  wire       fetch_rise = rose(fetch_n_q, fetch_n);
  wire       pix_rise   = rose(pixclk_q, pixclk);
  wire       host_start = read_rise && !mrd_n;
  wire [3:0] graph_code = {shifter[3][W-1], shifter[2][W-1], shifter[1][W-1], shifter[0][W-1]};
  wire [3:0] next_code  = text ? plane_in[1][plane_latch_pkg::TEXT_LSB +: 4] : graph_code;

  // Previous samples for edge detection.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      read_n_q  <= 1'b1;
      fetch_n_q <= 1'b1;
      pixclk_q  <= 1'b0;
    end
    else
    begin
      read_n_q  <= read_n;
      fetch_n_q <= fetch_n;
      pixclk_q  <= pixclk;
    end
  end

  // Per-plane latches and shifters; the shifter works only on a pixel edge.
  for (genvar p = 0; p < plane_latch_pkg::PLANES; p++)
  begin : g_plane
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
      begin
        rd_latch[p]    <= plane_latch_pkg::BYTE_RST;
        fetch_latch[p] <= plane_latch_pkg::BYTE_RST;
        shifter[p]     <= plane_latch_pkg::BYTE_RST;
      end
      else
      begin
        if (!read_n)
          rd_latch[p] <= plane_in[p];
        if (fetch_rise)
          fetch_latch[p] <= plane_in[p];
        if (pix_rise && !shload)
          shifter[p] <= fetch_latch[p];
        else if (pix_rise)
          shifter[p] <= {shifter[p][W-2:0], 1'b0};
      end
    end
  end

  // Host side: the read answer stands until memory read is released. The
  // start wins over the release so a back-to-back read is never dropped.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      host_data_o    <= plane_latch_pkg::BYTE_RST;
      host_data_oe_o <= 1'b0;
      write_reg      <= plane_latch_pkg::BYTE_RST;
    end
    else
    begin
      if (host_start)
      begin
        host_data_o    <= rd_latch[rd_sel];
        host_data_oe_o <= 1'b1;
      end
      else if (mrd_n)
        host_data_oe_o <= 1'b0;
      if (!iow_n)
        write_reg <= host_in;
    end
  end

  // Plane drivers and pixel code output, all registered.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      plane0_bus_o     <= plane_latch_pkg::BYTE_RST;
      plane1_bus_o     <= plane_latch_pkg::BYTE_RST;
      plane2_bus_o     <= plane_latch_pkg::BYTE_RST;
      plane3_bus_o     <= plane_latch_pkg::BYTE_RST;
      plane_bus_oe_o   <= 1'b0;
      pixel_code_out_o <= plane_latch_pkg::CODE_RST;
    end
    else
    begin
      plane0_bus_o     <= write_reg;
      plane1_bus_o     <= write_reg;
      plane2_bus_o     <= write_reg;
      plane3_bus_o     <= write_reg;
      plane_bus_oe_o   <= !drive_n;
      pixel_code_out_o <= next_code;
    end
  end

  // Checks on the data path.
  sequence s_host_waiting;
    host_data_oe_o && !mrd_n && !host_start;
  endsequence

  sequence s_host_answer;
    host_data_oe_o && (host_data_o == $past(rd_latch[rd_sel]));
  endsequence

  a_read_latch_capture: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !read_n |=> rd_latch[0] == $past(plane_in[0]) && rd_latch[3] == $past(plane_in[3]))
    else $error("read latch missed plane data");

  a_host_read_drive: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    host_start |=> s_host_answer)
    else $error("host bus not driven with latched data after read edge");

  a_host_release: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (mrd_n && !host_start) |=> !host_data_oe_o)
    else $error("host bus still driven after memory read release");

  a_fetch_load: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    fetch_rise |=> fetch_latch[2] == $past(plane_in[2]))
    else $error("refresh latch not loaded on fetch edge");

  a_shift_load: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (pix_rise && !shload) |=> shifter[1] == $past(fetch_latch[1]))
    else $error("shifter not loaded from refresh latch");

  a_shift_step: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (pix_rise && shload) |=> shifter[0] == {$past(shifter[0][W-2:0]), 1'b0})
    else $error("shifter did not advance by one bit");

  a_shift_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !pix_rise |=> $stable(shifter[3]))
    else $error("shifter moved without a pixel edge");

  a_plane_drive: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    1'b1 |=> plane_bus_oe_o == !$past(drive_n))
    else $error("plane buses driven while drive enable is high");

  a_reg_capture: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !iow_n |=> ##1 plane0_bus_o == $past(host_in, 2))
    else $error("write data not captured from io write");

  a_pixel_code: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    1'b1 |=> pixel_code_out_o == ($past(text) ? $past(plane_in[1][3:0]) : $past(graph_code)))
    else $error("pixel code source wrong for the mode");

  a_host_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    s_host_waiting |=> host_data_oe_o && $stable(host_data_o))
    else $error("host read answer dropped while memory read is low");
endmodule // plane_latch_shifter

//--- design/plane_latch_pkg.sv
/*
  Shared constants for the plane latch and shifter data path: bus widths,
  synchroniser depth and the bit layout of the synchronised input vector.
  Assumes nothing; it is included by compile order only.
*/
package plane_latch_pkg;
  localparam int PLANE_W      = 8;
  localparam int PLANES       = 4;
  localparam int SEL_W        = 2;
  localparam int SYNC_STAGES  = 2;
  // Positions inside the synchronised input vector.
  localparam int POS_READ_N   = 0;
  localparam int POS_FETCH_N  = 1;
  localparam int POS_PIXCLK   = 2;
  localparam int POS_SHLOAD   = 3;
  localparam int POS_MRD_N    = 4;
  localparam int POS_IOW_N    = 5;
  localparam int POS_DRIVE_N  = 6;
  localparam int POS_TEXT     = 7;
  localparam int POS_SEL      = 8;
  localparam int POS_PLANES   = POS_SEL + SEL_W;
  localparam int POS_HOST     = POS_PLANES + PLANES * PLANE_W;
  localparam int SYNC_W       = POS_HOST + PLANE_W;
  // Reset values.
  localparam logic [PLANE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [3:0]         CODE_RST = 4'h0;
  // Synchroniser reset: active-low strobes idle high. A zero here would make
  // a false read edge, write and plane drive while the stages refill.
  localparam logic [SYNC_W-1:0] SYNC_RST = SYNC_W'((1 << POS_READ_N) | (1 << POS_FETCH_N) | (1 << POS_MRD_N)
                                                   | (1 << POS_IOW_N) | (1 << POS_DRIVE_N));
  // Plane 1 bits passed straight through in text mode.
  localparam int TEXT_LSB     = 0;
endpackage

//--- design/pin_sync.sv
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes every bit is sampled independently; a multi-bit value is only
  trusted when the strobe that qualifies it is stable around it.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH   = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // Refuse a width that leaves nothing to synchronise.
  if (WIDTH < 1)
  begin : g_width_check
    $error("pin_sync needs WIDTH of at least one");
  end

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta   <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // pin_sync

//--- sim/plane_mem_model.sv
/*
  Four-plane display memory on the far side of the plane buses.
  Assumes the bench preloads it and the design writes it while driving.
*/
`timescale 1ns/1ps
module plane_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic        load_i,
  input  wire logic [31:0] load_data_i,
  input  wire logic        oe_i,
  input  wire logic [31:0] wr_data_i,
  output logic      [31:0] bus_o
);
  logic [31:0] mem;
  // A driving design owns the wires; otherwise the memory answers.
  assign bus_o = oe_i ? wr_data_i : mem;
  // Preload from the bench, else store what the design writes.
  always_ff @(posedge sys_clk_i)
  begin
    if (load_i)
      mem <= load_data_i;
    else if (oe_i)
      mem <= wr_data_i;
  end
endmodule // plane_mem_model

//--- sim/plane_latch_shifter_bench.sv
/*
  Self-checking bench for the plane latch and shifter.
  Assumes the memory model sits on the plane buses.
*/
`timescale 1ns/1ps
module plane_latch_shifter_bench;
  logic        sys_clk = 0, arst_n = 0, rd_n = 1, fetch_n = 1, pclk = 0;
  logic        shl = 1, mrd_n = 1, iow_n = 1, drv_n = 1, text = 0;
  logic        load = 0, chk = 0, hoe_q = 0, poe_q = 0;
  logic [1:0]  sel = 0;
  logic [7:0]  hd_i = 0;
  logic [31:0] ld = 0, d, seed = 32'h0000001b;
  logic [3:0]  e;
  logic [33:0] notes[$];
  wire  [31:0] wr, bus;
  wire  [7:0]  hd_o;
  wire  [3:0]  code;
  wire         hoe, poe;
  int          miscompares = 0, n_tests = 0;

  always #10 sys_clk = ~sys_clk;

  plane_latch_shifter u_plane_latch_shifter (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
    .host_read_latch_n_i(rd_n), .display_fetch_strobe_n_i(fetch_n), .pixel_shift_clock_i(pclk),
    .shift_load_sel_i(shl), .memory_read_strobe_n_i(mrd_n), .io_write_strobe_n_i(iow_n),
    .plane_drive_n_i(drv_n), .text_mode_i(text), .read_plane_sel_i(sel), .host_data_i(hd_i),
    .host_data_o(hd_o), .host_data_oe_o(hoe), .plane0_bus_i(bus[7:0]), .plane1_bus_i(bus[15:8]),
    .plane2_bus_i(bus[23:16]), .plane3_bus_i(bus[31:24]), .plane0_bus_o(wr[7:0]),
    .plane1_bus_o(wr[15:8]), .plane2_bus_o(wr[23:16]), .plane3_bus_o(wr[31:24]),
    .plane_bus_oe_o(poe), .pixel_code_out_o(code));

  plane_mem_model u_plane_mem_model (.sys_clk_i(sys_clk), .load_i(load), .load_data_i(ld),
    .oe_i(poe), .wr_data_i(wr), .bus_o(bus));

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic give_verdict();
    miscompares += notes.size();
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic compare(input logic [1:0] k, input logic [31:0] v);
    logic [33:0] x;
    n_tests++;
    x = (notes.size() > 0) ? notes.pop_front() : 34'h3ffffffff;
    if (x !== {k, v})
    begin
      miscompares++;
      $display("CHECK FAILED %0t kind %0d got %h want %h", $time, k, v, x[31:0]);
    end
  endtask

  // Each result that appears takes the oldest note off the queue.
  always @(posedge sys_clk)
  begin
    hoe_q <= hoe;
    poe_q <= poe;
    if (hoe === 1'b1 && hoe_q === 1'b0) compare(2'h0, {24'h0, hd_o});
    if (hoe === 1'b0 && hoe_q === 1'b1) compare(2'h3, {24'h0, hd_o});
    if (poe === 1'b1 && poe_q === 1'b0) compare(2'h1, wr);
    if (chk === 1'b1) compare(2'h2, {28'h0, code});
  end

  // Preloads memory; the plane buses settle a cycle before use.
  task automatic mem_load(input logic [31:0] v);
    load <= 1;
    ld <= v;
    cyc(1);
    load <= 0;
    cyc(1);
  endtask

  // A refused read leaves no note, so any drive shows as a stray result.
  task automatic host_read(input logic ok, input logic [7:0] x);
    if (ok) notes.push_back({2'h0, 24'h0, x});
    if (ok) notes.push_back({2'h3, 24'h0, x});
    rd_n <= 0;
    mrd_n <= !ok;
    cyc(4);
    rd_n <= 1;
    cyc(5);
    mrd_n <= 1;
    cyc(5);
  endtask

  // Both pixel clock phases last four cycles, above the sampler's minimum.
  task automatic pix();
    pclk <= 1;
    cyc(4);
    pclk <= 0;
    cyc(4);
  endtask

  task automatic code_check(input logic [3:0] x);
    notes.push_back({2'h2, 28'h0, x});
    chk <= 1;
    cyc(1);
    chk <= 0;
  endtask

  initial
  begin
    cyc(3);
    arst_n <= 1;
    cyc(3);
    // Every plane read once, then a read with memory read left high.
    for (int i = 0; i < 5; i++)
    begin
      d = xorshift();
      sel <= i[1:0];
      mem_load(d);
      host_read(i < 4, d[8*i[1:0] +: 8]);
    end
    // Register write, drive the planes, then read one plane back.
    d = xorshift();
    notes.push_back({2'h1, {4{d[7:0]}}});
    hd_i <= d[7:0];
    iow_n <= 0;
    cyc(3);
    iow_n <= 1;
    drv_n <= 0;
    cyc(5);
    drv_n <= 1;
    cyc(3);
    sel <= 2'h3;
    host_read(1, d[7:0]);
    // Fetch, then change memory so a load from live planes would differ.
    d = xorshift();
    mem_load(d);
    fetch_n <= 0;
    cyc(4);
    fetch_n <= 1;
    cyc(4);
    mem_load(~d);
    shl <= 0;
    cyc(2);
    pix();
    shl <= 1;
    for (int k = 0; k < 8; k++)
    begin
      if (k > 0) pix();
      for (int j = 0; j < 4; j++) e[j] = d[8*j + 7 - k];
      code_check(e);
    end
    // Text mode passes the low nibble of plane 1.
    text <= 1;
    cyc(6);
    code_check(~d[11:8]);
    // Let the monitor take the last note before the verdict is read.
    cyc(2);
    give_verdict();
  end

  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    #(20 * 5000);
    miscompares++;
    give_verdict();
  end
endmodule // plane_latch_shifter_bench
